// File: design/switch_timing_mode_select.sv
// Timing mode selector for the TDM switch: master, divided slave, multiplied slave.
// Assumes pins arrive asynchronously and config ports come from logic on clk.
//
// Overview of operation
// RL1 - Master mode takes every output clock and frame pulse from the loop.
// RL2 - Master input clock and frame come from loop outputs, internal or external.
// RL3 - Far parties in master mode follow the device output clock and frame.
// RL4 - Divided slave outputs are direct divisions of input clock and frame.
// RL5 - Divided slave output clocks never run faster than the input clock.
// RL6 - Multiplied slave outputs come from a multiplier locked to the input clock.
// RL7 - Multiplied slave makes every output clock and data rate available.
// RL8 - Slave input data is always sampled by the input clock.
// RL9 - Slave with loop disabled leaves the loop outputs idle.
// RL10 - Slave loop enable drives loop outputs locked to the reference.
// RL11 - Loop and switch timing stay independent; reference monitoring continues.
// RL12 - An oscillator, with its enable pin high, is needed whenever the loop runs.
// RL13 - Selector 00 picks master; loopback bit picks internal or external return. Code: 00 gives divided slave unless loop or oscillator enable is high.
// RL14 - Selector 01 with loop, or low bit 0 without, picks divided slave.
// RL15 - Selector 11 with loop, or low bit 1 without, picks multiplied slave.
// RL16 - Rate pins read 11 for a 4 MHz input clock, 00 otherwise.
// RL17 - Divided slave bypasses input clock to main output and times data.
// RL18 - Multiplied slave drives the multiplied clock out and times data with it.
// RL19 - An externally returned input clock is edge aligned to main output.
// RL20 - Master main clock tracks the reference, else freeruns or holds over.
// RL21 - Loopback bit routes loop clock and frame onto the input paths. Code does so in master mode only; slaves keep the input pins.
// RL22 - Mode inputs are static; any mode change restarts clock generation.
`timescale 1ns/10ps
module switch_timing_mode_select
  import timing_mode_pkg::*;
#(
  parameter int PLL_HALF = PLL_HALF_DEFAULT,
  parameter int FRAME_CLOCKS = FRAME_CLOCKS_DEFAULT
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Mode configuration
  input wire logic [1:0] op_mode_sel,
  input wire logic slave_pll_enable,
  input wire logic input_clock_loopback,
  input wire logic osc_enable_pin,
  input wire logic [1:0] input_clock_rate_pins,
  input wire logic [1:0] pll_ref_select,
  // Timing pins from the far side
  input wire logic serial_clock_in,
  input wire logic frame_pulse_in,
  input wire logic serial_data_in,
  input wire logic [3:0] pll_reference_in,
  // Switch timing outputs
  output logic main_clock_out,
  output logic main_clock_half,
  output logic frame_pulse_out,
  output logic serial_stream_out,
  output logic sample_valid,
  output logic sampled_data,
  // Loop timing outputs
  output logic pll_clock_out_a,
  output logic pll_clock_out_b,
  output logic pll_frame_out,
  // Status
  output timing_mode_pkg::timing_mode_t timing_mode,
  output timing_mode_pkg::pll_state_t pll_status,
  output logic rate_4m
);
  import timing_mode_pkg::*;

  localparam int FW = $clog2(FRAME_CLOCKS);
  localparam int HW = $clog2(PLL_HALF + 1);
  localparam int TW = $clog2(REF_LOSS_CYCLES);

  // Decodes the selector, falling back to slave when neither the loop enable nor the oscillator pin is high.
  function automatic timing_mode_t decode_mode(input logic [1:0] sel, input logic pll_en,
                                               input logic osc);
    timing_mode_t m;
    if (sel == SEL_MASTER && (pll_en || osc))
      m = MODE_MASTER;
    else if (pll_en && sel == SEL_DIVIDED)
      m = MODE_DIVIDED;
    else if (pll_en && sel == SEL_MULTIPLIED)
      m = MODE_MULTIPLIED;
    else if (sel[SEL_LOW_BIT])
      m = MODE_MULTIPLIED;
    else
      m = MODE_DIVIDED;
    return m;
  endfunction

  logic [SYNC_WIDTH-1:0] sync_level;
  logic [SYNC_WIDTH-1:0] sync_rise;
  timing_mode_t mode_q;
  timing_mode_t next_mode;
  logic pll_on_q;
  logic next_pll_on;
  logic loop_q;
  logic restart;
  logic ref_rise;
  pll_state_t pll_state;
  logic [TW-1:0] ref_timer;
  logic [HW-1:0] pll_cnt;
  logic pll_clk;
  logic pll_clk_b;
  logic pll_rise;
  logic [FW-1:0] frame_cnt;
  logic pll_frame;
  logic sclk_rise;
  logic in_rise;
  logic in_fp;
  logic [PERIOD_WIDTH-1:0] per_cnt;
  logic [PERIOD_WIDTH-1:0] period;
  logic [PERIOD_WIDTH-1:0] mult_step;
  logic [PERIOD_WIDTH-1:0] mult_cnt;
  logic mult_clk;
  logic next_main;

  // All timing pins from the far side pass a two-flop synchroniser before anything reads them.
  edge_sync #(.W(SYNC_WIDTH)) pin_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .async_in({serial_data_in, frame_pulse_in, serial_clock_in, pll_reference_in}),
    .level(sync_level),
    .rise(sync_rise),
    .fall()
  );

  // Mode decode; the loop only runs with an oscillator present.
  assign next_mode = decode_mode(op_mode_sel, slave_pll_enable, osc_enable_pin); // RL13 RL14 RL15
  assign next_pll_on = osc_enable_pin && (next_mode == MODE_MASTER || slave_pll_enable); // RL12
  assign restart = ce && (next_mode != mode_q || next_pll_on != pll_on_q ||
                          input_clock_loopback != loop_q); // RL22
  assign rate_4m = (input_clock_rate_pins == RATE_4M_CODE); // RL16
  assign timing_mode = mode_q;
  assign pll_status = pll_state;

  // Configuration is held static; a change costs one cycle of restart.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_q <= MODE_DIVIDED;
      pll_on_q <= 1'b0;
      loop_q <= 1'b0;
    end
    else if (ce)
    begin
      mode_q <= next_mode;
      pll_on_q <= next_pll_on;
      loop_q <= input_clock_loopback;
    end
  end

  // The loop watches only its reference, never the switch input clock.
  assign ref_rise = sync_rise[pll_ref_select] && pll_on_q; // RL11

  // Reference monitor: edge gives normal, silence from normal gives holdover.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pll_state <= PLL_OFF;
      ref_timer <= '0;
    end
    else if (ce)
    begin
      if (restart)
      begin
        pll_state <= PLL_FREERUN;
        ref_timer <= '0;
      end
      else if (!pll_on_q)
        pll_state <= PLL_OFF; // RL9
      else if (ref_rise)
      begin
        pll_state <= PLL_NORMAL; // RL20
        ref_timer <= '0;
      end
      else if (ref_timer == TW'(REF_LOSS_CYCLES - 1))
      begin
        if (pll_state == PLL_NORMAL)
          pll_state <= PLL_HOLDOVER; // RL20
      end
      else
        ref_timer <= ref_timer + 1'b1; // RL11
    end
  end

  // Loop oscillator; a reference edge realigns its phase. Holdover simply keeps
  // the last rate, which this model cannot distinguish from freerun.
  assign pll_rise = ce && pll_on_q && !restart && !pll_clk &&
                    (ref_rise || pll_cnt == HW'(PLL_HALF - 1));
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pll_cnt <= '0;
      pll_clk <= 1'b0;
    end
    else if (ce)
    begin
      if (restart || !pll_on_q)
      begin
        pll_cnt <= '0;
        pll_clk <= 1'b0;
      end
      else if (ref_rise)
      begin
        pll_cnt <= '0; // RL10 RL20
        pll_clk <= 1'b1;
      end
      else if (pll_cnt == HW'(PLL_HALF - 1))
      begin
        pll_cnt <= '0;
        pll_clk <= ~pll_clk;
      end
      else
        pll_cnt <= pll_cnt + 1'b1;
    end
  end

  // Half-rate loop clock and the frame pulse counted from loop clock edges.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pll_clk_b <= 1'b0;
      frame_cnt <= '0;
      pll_frame <= 1'b0;
    end
    else if (ce)
    begin
      if (restart || !pll_on_q)
      begin
        pll_clk_b <= 1'b0;
        frame_cnt <= '0;
        pll_frame <= 1'b0;
      end
      else if (pll_rise)
      begin
        pll_clk_b <= ~pll_clk_b;
        pll_frame <= (frame_cnt == '0);
        frame_cnt <= (frame_cnt == FW'(FRAME_CLOCKS - 1)) ? '0 : frame_cnt + 1'b1;
      end
    end
  end

  // Input timing: in master mode, loopback puts loop clock and frame on the input paths.
  assign sclk_rise = sync_rise[SYNC_SCLK];
  assign in_rise = (mode_q == MODE_MASTER && loop_q) ? pll_rise : (ce && sclk_rise); // RL21 RL2
  assign in_fp = (mode_q == MODE_MASTER && loop_q) ? pll_frame : sync_level[SYNC_FP]; // RL21

  // Input data is sampled only on input clock edges, which caps its rate.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sample_valid <= 1'b0;
      sampled_data <= 1'b0;
    end
    else if (ce)
    begin
      sample_valid <= in_rise; // RL8
      if (in_rise)
        sampled_data <= sync_level[SYNC_DATA]; // RL8
    end
  end

  // Input clock period measurement for the multiplier.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      per_cnt <= '0;
      period <= '0;
    end
    else if (ce)
    begin
      if (restart)
      begin
        per_cnt <= '0;
        period <= '0;
      end
      else if (sclk_rise)
      begin
        period <= per_cnt + 1'b1;
        per_cnt <= '0;
      end
      else if (per_cnt != '1)
        per_cnt <= per_cnt + 1'b1;
    end
  end

  // A slow 4 MHz input is multiplied further so every output rate stays reachable.
  assign mult_step = rate_4m ? (period >> MULT_SHIFT_4M) : (period >> MULT_SHIFT_FAST); // RL7

  // Multiplier clock, realigned to every rising input clock edge to stay locked.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mult_cnt <= '0;
      mult_clk <= 1'b0;
    end
    else if (ce)
    begin
      if (restart || mode_q != MODE_MULTIPLIED)
      begin
        mult_cnt <= '0;
        mult_clk <= 1'b0;
      end
      else if (sclk_rise)
      begin
        mult_cnt <= '0; // RL6
        mult_clk <= 1'b1;
      end
      else if (mult_cnt + 1'b1 >= mult_step)
      begin
        mult_cnt <= '0;
        mult_clk <= ~mult_clk;
      end
      else
        mult_cnt <= mult_cnt + 1'b1;
    end
  end

  // Main clock source per mode.
  always_comb
  begin
    case (mode_q)
      MODE_MASTER: next_main = pll_clk; // RL1 RL20
      MODE_DIVIDED: next_main = sync_level[SYNC_SCLK]; // RL17 RL4 RL5
      MODE_MULTIPLIED: next_main = mult_clk; // RL18
      default: next_main = 1'b0;
    endcase
  end

  // Switch outputs: data changes on the falling main clock edge so the far
  // side can sample on the rising one.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      main_clock_out <= 1'b0;
      main_clock_half <= 1'b0;
      frame_pulse_out <= 1'b0;
      serial_stream_out <= 1'b0;
    end
    else if (ce)
    begin
      main_clock_out <= next_main;
      frame_pulse_out <= (mode_q == MODE_MASTER) ? pll_frame : in_fp; // RL1 RL4
      if (restart)
        main_clock_half <= 1'b0;
      else if (next_main && !main_clock_out)
        main_clock_half <= ~main_clock_half; // RL4 RL5
      if (!next_main && main_clock_out)
        serial_stream_out <= sampled_data; // RL17 RL18
    end
  end

  // Loop outputs stay low unless the loop runs.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pll_clock_out_a <= 1'b0;
      pll_clock_out_b <= 1'b0;
      pll_frame_out <= 1'b0;
    end
    else if (ce)
    begin
      pll_clock_out_a <= pll_on_q && pll_clk; // RL9 RL10
      pll_clock_out_b <= pll_on_q && pll_clk_b; // RL9 RL10
      pll_frame_out <= pll_on_q && pll_frame; // RL9 RL10
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence ref_edge_s;
    ce && ref_rise && !restart;
  endsequence

  sequence lost_ref_s;
    ce && pll_on_q && !restart && !ref_rise && pll_state == PLL_NORMAL &&
      ref_timer == TW'(REF_LOSS_CYCLES - 1);
  endsequence

  pll_idle_a: assert property ($past(ce) && !$past(pll_on_q) |-> // RL9
    !pll_clock_out_a && !pll_clock_out_b && !pll_frame_out)
    else $error("Loop outputs active while the loop is off.");

  master_clock_a: assert property ($past(ce) && $past(mode_q) == MODE_MASTER |-> // RL1
    main_clock_out == $past(pll_clk))
    else $error("Master main clock does not follow the loop.");

  divided_bypass_a: assert property ($past(ce) && $past(mode_q) == MODE_DIVIDED |-> // RL17
    main_clock_out == $past(sync_level[SYNC_SCLK]))
    else $error("Divided main clock is not the input clock.");

  multiplied_clock_a: assert property ($past(ce) && $past(mode_q) == MODE_MULTIPLIED |-> // RL18
    main_clock_out == $past(mult_clk))
    else $error("Multiplied main clock is not the multiplier output.");

  input_sample_a: assert property (ce && in_rise |=> // RL8
    sample_valid && sampled_data == $past(sync_level[SYNC_DATA]))
    else $error("Input data not sampled on the input clock edge.");

  loop_route_a: assert property (ce && mode_q == MODE_MASTER && loop_q && pll_rise |=> // RL21
    sample_valid)
    else $error("Loopback clock does not reach the input sampler.");

  ref_align_a: assert property (ref_edge_s |=> pll_clk && pll_cnt == '0 && // RL10
    pll_state == PLL_NORMAL)
    else $error("Loop did not lock to the reference edge.");

  holdover_a: assert property (lost_ref_s |=> pll_state == PLL_HOLDOVER) // RL20
    else $error("Lost reference did not enter holdover.");

  restart_a: assert property (restart |=> pll_cnt == '0 && !pll_clk && !mult_clk && // RL22
    frame_cnt == '0)
    else $error("Generators not restarted after a mode change.");
endmodule

// File: design/timing_mode_pkg.sv
// Shared constants and types for the TDM switch timing mode selector.
// Assumes a single 10 MHz system clock; clocks are modelled as sampled levels.
package timing_mode_pkg;

  // System clock period and the reference loss window.
  localparam int CLK_PERIOD_NS = 100;
  localparam int REF_LOSS_TIME_NS = 250000;
  localparam int REF_LOSS_CYCLES = REF_LOSS_TIME_NS / CLK_PERIOD_NS;

  // Operating mode selector encodings.
  localparam logic [1:0] SEL_MASTER = 2'h0;
  localparam logic [1:0] SEL_DIVIDED = 2'h1;
  localparam logic [1:0] SEL_MULTIPLIED = 2'h3;
  localparam int SEL_LOW_BIT = 0;

  // Input clock rate strap encodings.
  localparam logic [1:0] RATE_4M_CODE = 2'h3;
  localparam logic [1:0] RATE_8_16M_CODE = 2'h0;

  // Generator defaults.
  localparam int PLL_HALF_DEFAULT = 2;
  localparam int FRAME_CLOCKS_DEFAULT = 2048;
  localparam int MULT_SHIFT_4M = 3;
  localparam int MULT_SHIFT_FAST = 2;
  localparam int PERIOD_WIDTH = 8;

  // Synchroniser bit positions.
  localparam int SYNC_WIDTH = 7;
  localparam int SYNC_SCLK = 4;
  localparam int SYNC_FP = 5;
  localparam int SYNC_DATA = 6;

  typedef enum logic [1:0] {MODE_MASTER, MODE_DIVIDED, MODE_MULTIPLIED} timing_mode_t;
  typedef enum logic [1:0] {PLL_OFF, PLL_FREERUN, PLL_NORMAL, PLL_HOLDOVER} pll_state_t;

endpackage

// File: design/edge_sync.sv
// Two-flop synchroniser bank with edge detection on the settled stage.
// Assumes inputs are asynchronous pins; the first stage feeds only the second.
`timescale 1ns/10ps
module edge_sync #(
  parameter int W = 1
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Asynchronous inputs
  input wire logic [W-1:0] async_in,
  // Synchronised level and edge pulses
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta;
  logic [W-1:0] stage;
  logic [W-1:0] prev;

  // Metastability stages and the history flop for edge detection.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= '0;
      stage <= '0;
      prev <= '0;
    end
    else if (ce)
    begin
      meta <= async_in;
      stage <= meta;
      prev <= stage;
    end
  end

  // Edges look only at settled stages, never at the first flop.
  assign level = stage;
  assign rise = stage & ~prev;
  assign fall = ~stage & prev;
endmodule

// File: tb/tdm_far_side.sv
// Far-side model: a TDM timing source driving input clock, frame, data and references.
// Assumes clk is the bench system clock; every pin changes just after its rising edge.
`timescale 1ns/10ps
module tdm_far_side (
  // Clock and controls
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] half,
  input wire logic ref_run,
  input wire logic [1:0] ref_sel,
  // External return of the switch main clock
  input wire logic echo,
  input wire logic echo_clk,
  // Pins toward the switch
  output logic serial_clock_in,
  output logic frame_pulse_in,
  output logic serial_data_in,
  output logic [3:0] pll_reference_in
);
  logic [7:0] phase;
  logic [7:0] bits;
  logic [3:0] ref_cnt;

  // Everything starts idle so the switch sees clean levels at time zero.
  initial
  begin
    serial_clock_in = 1'b0;
    frame_pulse_in = 1'b0;
    serial_data_in = 1'b0;
    pll_reference_in = 4'h0;
    phase = 8'h00;
    bits = 8'h00;
    ref_cnt = 4'h0;
  end

  // The clock stands still between runs; released data keeps flipping so no stale bit passes.
  // An external return copies the main clock back, one system clock late, as a short cable would.
  always @(posedge clk)
  begin
    if (echo)
      serial_clock_in <= echo_clk;
    else if (!run)
    begin
      serial_clock_in <= 1'b0;
      frame_pulse_in <= 1'b0;
      serial_data_in <= ~serial_data_in;
      phase <= 8'h00;
    end
    else if (phase == half - 8'h01)
    begin
      phase <= 8'h00;
      serial_clock_in <= ~serial_clock_in;
      if (serial_clock_in)
      begin
        bits <= bits + 8'h01;
        serial_data_in <= bits[0] ^ bits[2];
        frame_pulse_in <= (bits[2:0] == 3'h7);
      end
    end
    else
      phase <= phase + 8'h01;
  end

  // Only the selected reference carries a square wave; the other sources stay low.
  always @(posedge clk)
  begin
    ref_cnt <= ref_cnt + 4'h1;
    pll_reference_in <= ref_run ? (4'(ref_cnt[3]) << ref_sel) : 4'h0;
  end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the timing mode selector, with the far-side model attached.
// Assumes the loop runs fast (PLL_HALF 1, FRAME_CLOCKS 4) to keep the run short.
`timescale 1ns/10ps
module testbench;
  import timing_mode_pkg::*;
  logic clk, resetn, ce, slave_pll_enable, input_clock_loopback, osc_enable_pin;
  logic [1:0] op_mode_sel, input_clock_rate_pins, ref_sel;
  logic serial_clock_in, frame_pulse_in, serial_data_in, run, ref_run;
  logic [3:0] pll_reference_in;
  logic [7:0] half;
  logic main_clock_out, main_clock_half, frame_pulse_out, serial_stream_out;
  logic sample_valid, sampled_data, pll_clock_out_a, pll_clock_out_b, pll_frame_out, rate_4m;
  timing_mode_t timing_mode;
  pll_state_t pll_status;
  logic [6:0] watch;
  logic [5:0] tbl [8] = '{6'h0C, 6'h1D, 6'h3E, 6'h21, 6'h32, 6'h12, 6'h01, 6'h16};
  logic exp_q [$];
  logic check_en;
  logic lp_on, echo, prev_main, prev_data;
  int cnt [7];
  int n_mismatch, checked, n_samp, took, n_valid;

  assign watch = {main_clock_half, pll_clock_out_b, pll_frame_out, frame_pulse_out,
                  pll_clock_out_a, serial_clock_in, main_clock_out};

  switch_timing_mode_select #(.PLL_HALF(1), .FRAME_CLOCKS(4)) uut (
    .clk(clk), .resetn(resetn), .ce(ce), .op_mode_sel(op_mode_sel),
    .slave_pll_enable(slave_pll_enable), .input_clock_loopback(input_clock_loopback),
    .osc_enable_pin(osc_enable_pin), .input_clock_rate_pins(input_clock_rate_pins),
    .pll_ref_select(ref_sel), .serial_clock_in(serial_clock_in),
    .frame_pulse_in(frame_pulse_in), .serial_data_in(serial_data_in),
    .pll_reference_in(pll_reference_in), .main_clock_out(main_clock_out),
    .main_clock_half(main_clock_half), .frame_pulse_out(frame_pulse_out),
    .serial_stream_out(serial_stream_out), .sample_valid(sample_valid),
    .sampled_data(sampled_data), .pll_clock_out_a(pll_clock_out_a),
    .pll_clock_out_b(pll_clock_out_b), .pll_frame_out(pll_frame_out),
    .timing_mode(timing_mode), .pll_status(pll_status), .rate_4m(rate_4m)
  );

  tdm_far_side far (
    .clk(clk), .run(run), .half(half), .ref_run(ref_run), .ref_sel(ref_sel),
    .echo(echo), .echo_clk(main_clock_out),
    .serial_clock_in(serial_clock_in), .frame_pulse_in(frame_pulse_in),
    .serial_data_in(serial_data_in), .pll_reference_in(pll_reference_in)
  );

  // The system clock runs at 10 MHz.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Config changes restart generation, so each one is given a few edges to settle.
  task automatic set_cfg(input logic [1:0] m, input logic p, input logic o, input logic lp);
    @(posedge clk);
    op_mode_sel <= m;
    slave_pll_enable <= p;
    osc_enable_pin <= o;
    input_clock_loopback <= lp;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // Counts rising levels of the watched clocks over n settled samples.
  task automatic count(input int n);
    logic [6:0] prev;
    prev = watch;
    cnt = '{default: 0};
    repeat (n)
    begin
      @(negedge clk);
      for (int k = 0; k < 7; k++)
        if (watch[k] === 1'b1 && prev[k] === 1'b0)
          cnt[k]++;
      prev = watch;
    end
  endtask

  // A wait that runs past its bound counts as a mismatch and ends the run.
  task automatic wait_status(input pll_state_t exp, input int bound);
    took = 0;
    while (pll_status !== exp)
    begin
      @(negedge clk);
      took++;
      if (took > bound)
      begin
        n_mismatch++;
        $display("MISMATCH pll_status wait expected %0d seen %0d", exp, pll_status);
        tally_and_finish();
      end
    end
  endtask

  // Each input clock rise captures the bit the switch should sample for it.
  always @(posedge serial_clock_in)
    if (check_en)
      exp_q.push_back(serial_data_in);

  // Each sample strobe must carry the oldest captured bit, and each fall of the
  // main clock must put the last sampled bit on the stream output.
  always @(negedge clk)
  begin
    if (sample_valid === 1'b1)
      n_valid++;
    if (check_en && sample_valid === 1'b1 && exp_q.size() > 0)
    begin
      n_samp++;
      check("sampled_data", 12'(sampled_data), 12'(exp_q.pop_front()));
    end
    if (check_en && prev_main === 1'b1 && main_clock_out === 1'b0)
      check("serial_stream_out", 12'(serial_stream_out), 12'(prev_data));
    prev_main = main_clock_out;
    prev_data = sampled_data;
  end

  // Main sequence.
  initial
  begin
    resetn = 1'b0;
    ce = 1'b1;
    op_mode_sel = 2'h0;
    slave_pll_enable = 1'b0;
    osc_enable_pin = 1'b0;
    input_clock_loopback = 1'b0;
    input_clock_rate_pins = 2'h0;
    ref_sel = 2'h2;
    run = 1'b0;
    half = 8'h04;
    ref_run = 1'b0;
    echo = 1'b0;
    check_en = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check("reset mode", 12'(timing_mode), 12'(MODE_DIVIDED));
    check("reset loop", 12'(pll_status), 12'(PLL_OFF));
    @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      set_cfg(tbl[i][5:4], tbl[i][3], tbl[i][2], 1'b0);
      lp_on = tbl[i][2] & (tbl[i][3] | (tbl[i][1:0] == 2'h0));
      check("mode", 12'(timing_mode), 12'(tbl[i][1:0]));
      check("loop state", 12'(pll_status), lp_on ? 12'(PLL_FREERUN) : 12'(PLL_OFF));
      count(40);
      check("loop clock", 12'(cnt[2] > 0), 12'(lp_on));
    end
    // The rate straps follow the input clock rate.
    @(posedge clk);
    input_clock_rate_pins <= 2'h3;
    @(negedge clk);
    check("rate 4m", 12'(rate_4m), 12'h001);
    @(posedge clk);
    input_clock_rate_pins <= 2'h0;
    @(negedge clk);
    check("rate fast", 12'(rate_4m), 12'h000);
    // Divided slave with the loop locked to a separate reference.
    set_cfg(2'h1, 1'b1, 1'b1, 1'b0);
    ref_run <= 1'b1;
    exp_q.delete();
    check_en <= 1'b1;
    run <= 1'b1;
    wait_status(PLL_NORMAL, 200);
    count(200);
    check("divided rate", 12'(cnt[0] <= cnt[1] + 1 && cnt[1] <= cnt[0] + 1), 12'h001);
    check("main half", 12'(cnt[6] * 2 + 1 >= cnt[0] && cnt[6] * 2 <= cnt[0] + 1), 12'h001);
    check("slave frame", 12'(cnt[3] > 0), 12'h001);
    check("loop kept", 12'(pll_status), 12'(PLL_NORMAL));
    check_en <= 1'b0;
    check("samples seen", 12'(n_samp > 10), 12'h001);
    // Multiplied slave at both input clock rates. The first window lets the period
    // measurement settle; the second spans whole input periods, so counts are exact.
    set_cfg(2'h3, 1'b1, 1'b1, 1'b0);
    count(48);
    count(200);
    check("mult rate", 12'(cnt[0]), 12'(cnt[1] << (MULT_SHIFT_FAST - 1)));
    check("mult input", 12'(cnt[1] > 5), 12'h001);
    @(posedge clk);
    half <= 8'h08;
    input_clock_rate_pins <= 2'h3;
    count(48);
    count(320);
    check("mult 4m rate", 12'(cnt[0]), 12'(cnt[1] << (MULT_SHIFT_4M - 1)));
    check("mult 4m input", 12'(cnt[1] > 5), 12'h001);
    @(posedge clk);
    input_clock_rate_pins <= 2'h0;
    run <= 1'b0;
    ref_run <= 1'b0;
    // Master with internal loopback and no far-side clock.
    set_cfg(2'h0, 1'b0, 1'b1, 1'b1);
    check("master mode", 12'(timing_mode), 12'(MODE_MASTER));
    n_valid = 0;
    count(100);
    check("master clock", 12'(cnt[0] > 0 && cnt[4] > 0), 12'h001);
    check("loopback frame", 12'(cnt[3] > 0), 12'h001);
    check("loopback sample", 12'(n_valid > 5), 12'h001);
    check("clock b", 12'(cnt[5] * 2 + 1 >= cnt[2] && cnt[5] * 2 <= cnt[2] + 1), 12'h001);
    // Master with the main clock returned through the far side.
    @(posedge clk);
    echo <= 1'b1;
    set_cfg(2'h0, 1'b0, 1'b1, 1'b0);
    n_valid = 0;
    count(40);
    check("external return", 12'(n_valid > 5), 12'h001);
    echo <= 1'b0;
    ref_run <= 1'b1;
    wait_status(PLL_NORMAL, 200);
    ref_run <= 1'b0;
    wait_status(PLL_HOLDOVER, 2700);
    check("holdover delay", 12'(took >= 2400), 12'h001);
    // A frozen block ignores config changes.
    @(posedge clk);
    ce <= 1'b0;
    set_cfg(2'h3, 1'b1, 1'b1, 1'b0);
    check("frozen mode", 12'(timing_mode), 12'(MODE_MASTER));
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(negedge clk);
    check("thawed mode", 12'(timing_mode), 12'(MODE_MULTIPLIED));
    tally_and_finish();
  end
endmodule
